// File: core/sccp_pkg.sv
// Purpose: Shared constants and types for the system clock select and
//          prescale block.
// Assumes: One master clock; fuse levels are static after power-up.
// Notes:   Register indices are word addresses on the plain register port.
package sccp_pkg;

  // Register port geometry and register indices.
  localparam int unsigned ADDR_W        = 4;
  localparam int unsigned DATA_W        = 8;
  localparam logic [3:0]  ADDR_OSC_TRIM = 4'h0;
  localparam logic [3:0]  ADDR_DIV_CTRL = 4'h1;

  // Field positions.
  localparam int unsigned TRIM_MSB      = 6;
  localparam int unsigned UNLOCK_BIT    = 7;
  localparam int unsigned DIVSEL_MSB    = 3;

  // Reset and special values.
  localparam logic [6:0]  TRIM_MAX        = 7'h7F;
  localparam logic [3:0]  DIVSEL_RST_DIV1 = 4'h0;
  localparam logic [3:0]  DIVSEL_RST_DIV8 = 4'h3;
  localparam logic [3:0]  DIVSEL_MAX      = 4'h8;
  localparam logic [7:0]  UNLOCK_WORD     = 8'h80;
  localparam logic [2:0]  UNLOCK_TICKS    = 3'h4;
  localparam logic [7:0]  RD_UNMAPPED     = 8'h00;

  // Clock source fuse codes.
  localparam logic [3:0]  CKSRC_EXT_A     = 4'h0;
  localparam logic [3:0]  CKSRC_EXT_B     = 4'h1;
  localparam logic [3:0]  CKSRC_RC4_A     = 4'h2;
  localparam logic [3:0]  CKSRC_RC4_B     = 4'h3;
  localparam logic [3:0]  CKSRC_RC8_A     = 4'h4;
  localparam logic [3:0]  CKSRC_RC8_B     = 4'h5;
  localparam logic [3:0]  CKSRC_LP128K    = 4'h6;

  // Start-up delay fuse codes.
  localparam logic [1:0]  SUT_BASE        = 2'h0;
  localparam logic [1:0]  SUT_SHORT       = 2'h1;
  localparam logic [1:0]  SUT_LONG        = 2'h2;
  localparam logic [1:0]  SUT_RESERVED    = 2'h3;

  // Start-up timing in source clock and watchdog oscillator cycles.
  localparam int unsigned START_CNT_W     = 14;
  localparam int unsigned RESET_BASE_CK   = 14;
  localparam int unsigned WAKE_CK         = 6;
  localparam int unsigned WDT_SHORT_CYC   = 512;
  localparam int unsigned WDT_LONG_CYC    = 8192;

  // Prescaler counter width: enough for the largest divide of 256.
  localparam int unsigned PRESCALE_CNT_W  = 8;

  typedef enum logic [2:0] {
    SRC_EXT         = 3'h0,
    SRC_RC4M        = 3'h1,
    SRC_RC8M        = 3'h3,
    SRC_LP128K      = 3'h2,
    SRC_UNSUPPORTED = 3'h6
  } sccp_src_t;

  typedef enum logic [1:0] {
    ST_BASE = 2'b00,
    ST_EXT  = 2'b01,
    ST_RUN  = 2'b11,
    ST_WAKE = 2'b10
  } sccp_start_t;

endpackage : sccp_pkg

// File: core/sccp_prescale.sv
// Purpose: Divide counter producing one enable tick per divided period.
// Assumes: div_log2 changes only in a cycle where tick is high.
// Notes:   A synchronous counter stands in for the ripple chain.
`timescale 1ns/10ps
module sccp_prescale #(
  parameter int unsigned CNT_W = sccp_pkg::PRESCALE_CNT_W
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_div_log2,
  output logic            o_tick
);
  import sccp_pkg::*;

  logic [CNT_W:0]   span;
  logic [CNT_W-1:0] last;
  logic [CNT_W-1:0] cnt_q;

  // A divide of 2^CNT_W wraps to all ones in the low bits, as intended.
  assign span   = {{CNT_W{1'b0}}, 1'b1} << i_div_log2;
  assign last   = span[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
  assign o_tick = (cnt_q == last);

  // The count restarts on every tick, so a new setting always gets a
  // full period of its own and never a short one.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (o_tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule : sccp_prescale

// File: core/sccp_startup.sv
// Purpose: Reset time-out and power-down wake delay sequencer.
// Assumes: i_wdt_edge is a one-cycle pulse already synchronised.
// Notes:   The reserved delay code is treated as the longest delay.
`timescale 1ns/10ps
module sccp_startup #(
  parameter int unsigned BASE_CK  = sccp_pkg::RESET_BASE_CK,
  parameter int unsigned WAKE_CK  = sccp_pkg::WAKE_CK,
  parameter int unsigned SHORT_WD = sccp_pkg::WDT_SHORT_CYC,
  parameter int unsigned LONG_WD  = sccp_pkg::WDT_LONG_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_sut,
  input  wire logic       i_wdt_edge,
  input  wire logic       i_power_down,
  output logic            o_ready
);
  import sccp_pkg::*;

  localparam logic [START_CNT_W-1:0] BASE_LAST  = START_CNT_W'(BASE_CK - 1);
  localparam logic [START_CNT_W-1:0] WAKE_LAST  = START_CNT_W'(WAKE_CK - 1);
  localparam logic [START_CNT_W-1:0] SHORT_LAST = START_CNT_W'(SHORT_WD - 1);
  localparam logic [START_CNT_W-1:0] LONG_LAST  = START_CNT_W'(LONG_WD - 1);

  sccp_start_t             state_q;
  logic [START_CNT_W-1:0]  cnt_q;
  logic [START_CNT_W-1:0]  ext_last;
  logic                    ext_none;

  always_comb begin
    ext_none = 1'b0;
    ext_last = LONG_LAST;
    case (i_sut)
      SUT_BASE:  ext_none = 1'b1;
      SUT_SHORT: ext_last = SHORT_LAST;
      default:   ext_last = LONG_LAST;
    endcase
  end

  assign o_ready = (state_q == ST_RUN);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ST_BASE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        ST_BASE: begin
          if (cnt_q == BASE_LAST) begin
            cnt_q   <= '0;
            state_q <= ext_none ? ST_RUN : ST_EXT;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_EXT: begin
          if (i_wdt_edge) begin
            if (cnt_q == ext_last) begin
              cnt_q   <= '0;
              state_q <= ST_RUN;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (i_power_down) begin
            cnt_q   <= '0;
            state_q <= ST_WAKE;
          end
        end
        default: begin
          if (!i_power_down) begin
            if (cnt_q == WAKE_LAST) begin
              cnt_q   <= '0;
              state_q <= ST_RUN;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
      endcase
    end
  end

endmodule : sccp_startup

// File: core/sccp_top.sv
// Purpose: System clock control: oscillator trim, source selection,
//          start-up delays and a locked, glitch-free clock prescaler.
// Assumes: I_CLK_SYS is the undivided master clock of the chosen source.
// Notes:   The divided clock leaves as an enable tick on the master clock.
`timescale 1ns/10ps

// Summary of operation
// RULE1 - Trim 0 is slowest, larger codes faster, 0x7F fastest.
// RULE2 - Reset loads the factory trim byte with no software help.
// RULE3 - Software moves trim by at most 0x20 per step.
// RULE4 - Software keeps trim under 10% above nominal during memory writes.
// RULE5 - Source code 0000 or 0001 selects the external pin clock.
// RULE6 - External clock: wake 6 cycles; reset 14, +4.1 ms, +65 ms.
// RULE7 - Source code 0110 selects the 128 kHz low-power oscillator.
// RULE8 - 128 kHz source: wake 6 cycles; reset 14, +4 ms, +64 ms.
// RULE9 - External clock changes stay under 2% and happen under reset.
// RULE10 - Prescaler works for every source and divides all core clocks.
// RULE11 - Divide changes never make a period shorter than old or new.
// RULE12 - New rate takes effect after one old and one or two new periods; here it applies from the tick ending the current old period.
// RULE13 - Prescaler counts on the master clock; its count is unreadable.
// RULE14 - Divide change: unlock write first, then value within four cycles.
// RULE15 - Unlock bit changes only when the other bits are written zero.
// RULE16 - Unlock clears after four cycles or on a divide write; no restart.
// RULE17 - Software keeps interrupts off during the unlock sequence.
// RULE18 - Reset loads divide 0000, or 0011 when the div8 fuse is set.
// RULE19 - After unlock any divide value is accepted, whatever the fuse.
// RULE20 - Divide codes 0 to 8 give 1 to 256; codes 9 to 15 reserved.
// RULE21 - Source codes 0010-0011 give RC 4 MHz, 0100-0101 RC 8 MHz.
// RULE22 - Reset extensions count 512 or 8192 watchdog oscillator cycles.
// RULE23 - A reserved divide code keeps the previous division factor.
// RULE24 - Unlock window counts divided cycles after the unlock write.
module sccp_top #(
  parameter int unsigned WDT_SHORT = sccp_pkg::WDT_SHORT_CYC,
  parameter int unsigned WDT_LONG  = sccp_pkg::WDT_LONG_CYC
) (
  input  wire logic                        I_CLK_SYS,
  input  wire logic                        I_SRST,
  input  wire logic [sccp_pkg::ADDR_W-1:0] I_ADDR,
  input  wire logic [sccp_pkg::DATA_W-1:0] I_WR_DATA,
  input  wire logic                        I_WR_STB,
  input  wire logic                        I_RD_STB,
  output logic      [sccp_pkg::DATA_W-1:0] O_RD_DATA,
  input  wire logic [6:0]                  I_FACTORY_TRIM,
  input  wire logic [3:0]                  I_CLOCK_SOURCE_FUSE,
  input  wire logic [1:0]                  I_STARTUP_DELAY_FUSE,
  input  wire logic                        I_INITIAL_DIV8_FUSE,
  input  wire logic                        I_WDT_OSC,
  input  wire logic                        I_POWER_DOWN,
  output logic      [6:0]                  O_TRIM_VALUE,
  output sccp_pkg::sccp_src_t              O_CLOCK_SOURCE,
  output logic                             O_OSC_INPUT_EN,
  output logic                             O_SYS_CLK_EN,
  output logic      [3:0]                  O_DIV_LOG2,
  output logic                             O_CLK_READY,
  output logic                             O_DIV_UNLOCKED
);
  import sccp_pkg::*;

  // Synchronisers for pins and fuse levels.
  logic [6:0]  trim_fuse_m_q;
  logic [6:0]  trim_fuse_s_q;
  logic [3:0]  src_fuse_m_q;
  logic [3:0]  src_fuse_s_q;
  logic [1:0]  sut_fuse_m_q;
  logic [1:0]  sut_fuse_s_q;
  logic        div8_fuse_m_q;
  logic        div8_fuse_s_q;
  logic        wdt_m_q;
  logic        wdt_s_q;
  logic        wdt_d_q;
  logic        wdt_edge;

  // Register state.
  logic [6:0]  trim_q;
  logic [3:0]  div_sel_q;
  logic [3:0]  div_applied_q;
  logic        unlock_q;
  logic [2:0]  unlock_cnt_q;
  logic [7:0]  rd_data_q;
  sccp_src_t   src_q;

  // Decode.
  logic        wr_trim;
  logic        wr_ctrl;
  logic        wr_unlock;
  logic        wr_divsel;
  logic        sel_legal;
  logic        tick;
  logic        ready;
  sccp_src_t   src_d;

  // Fuse levels are static, so no reset is needed on these stages.
  always_ff @(posedge I_CLK_SYS) begin
    trim_fuse_m_q <= I_FACTORY_TRIM;
    trim_fuse_s_q <= trim_fuse_m_q;
    src_fuse_m_q  <= I_CLOCK_SOURCE_FUSE;
    src_fuse_s_q  <= src_fuse_m_q;
    sut_fuse_m_q  <= I_STARTUP_DELAY_FUSE;
    sut_fuse_s_q  <= sut_fuse_m_q;
    div8_fuse_m_q <= I_INITIAL_DIV8_FUSE;
    div8_fuse_s_q <= div8_fuse_m_q;
  end

  // The watchdog oscillator is asynchronous; edges are found after the
  // second stage so the first stage feeds nothing else.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      wdt_m_q <= 1'b0;
      wdt_s_q <= 1'b0;
      wdt_d_q <= 1'b0;
    end else begin
      wdt_m_q <= I_WDT_OSC;
      wdt_s_q <= wdt_m_q;
      wdt_d_q <= wdt_s_q;
    end
  end

  assign wdt_edge = wdt_s_q & ~wdt_d_q;

  // Clock source selection from the fuse code.
  always_comb begin
    if ((src_fuse_s_q == CKSRC_EXT_A) || (src_fuse_s_q == CKSRC_EXT_B)) begin
      src_d = SRC_EXT; // RULE5
    end else if ((src_fuse_s_q == CKSRC_RC4_A) ||
                 (src_fuse_s_q == CKSRC_RC4_B)) begin
      src_d = SRC_RC4M; // RULE21
    end else if ((src_fuse_s_q == CKSRC_RC8_A) ||
                 (src_fuse_s_q == CKSRC_RC8_B)) begin
      src_d = SRC_RC8M; // RULE21
    end else if (src_fuse_s_q == CKSRC_LP128K) begin
      src_d = SRC_LP128K; // RULE7
    end else begin
      src_d = SRC_UNSUPPORTED;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      src_q <= SRC_UNSUPPORTED;
    end else begin
      src_q <= src_d;
    end
  end

  assign O_CLOCK_SOURCE = src_q;
  assign O_OSC_INPUT_EN = (src_q == SRC_EXT); // RULE5

  // Start-up delays are the same counts for the external and the 128 kHz
  // sources; the watchdog oscillator paces the long extensions.
  sccp_startup #(
    .BASE_CK  (RESET_BASE_CK),
    .WAKE_CK  (WAKE_CK),
    .SHORT_WD (WDT_SHORT),
    .LONG_WD  (WDT_LONG)
  ) u_startup (
    .i_clk        (I_CLK_SYS),
    .i_rst        (I_SRST),
    .i_sut        (sut_fuse_s_q),
    .i_wdt_edge   (wdt_edge),
    .i_power_down (I_POWER_DOWN),
    .o_ready      (ready)
  ); // RULE6 RULE8 RULE22

  assign O_CLK_READY = ready;

  // Register decode.
  always_comb begin
    wr_trim = 1'b0;
    wr_ctrl = 1'b0;
    if (I_WR_STB && (I_ADDR == ADDR_OSC_TRIM)) begin
      wr_trim = 1'b1;
    end else if (I_WR_STB && (I_ADDR == ADDR_DIV_CTRL)) begin
      wr_ctrl = 1'b1;
    end
  end

  // Only the exact unlock word sets the unlock bit.
  assign wr_unlock = wr_ctrl && (I_WR_DATA == UNLOCK_WORD); // RULE15
  assign wr_divsel = wr_ctrl && !I_WR_DATA[UNLOCK_BIT] && unlock_q; // RULE14
  assign sel_legal = (I_WR_DATA[DIVSEL_MSB:0] <= DIVSEL_MAX); // RULE20

  // Oscillator trim: reset takes the factory byte; the code drives the
  // oscillator directly, so a larger code means a faster clock.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      trim_q <= trim_fuse_s_q; // RULE2
    end else if (wr_trim) begin
      trim_q <= I_WR_DATA[TRIM_MSB:0]; // RULE1
    end
  end

  assign O_TRIM_VALUE = trim_q; // RULE1

  // Unlock bit and its window. A repeated unlock write while open is
  // ignored, so the window cannot be stretched by software.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      unlock_q     <= 1'b0;
      unlock_cnt_q <= 3'h0;
    end else if (wr_divsel) begin
      unlock_q     <= 1'b0; // RULE16
      unlock_cnt_q <= 3'h0;
    end else if (wr_unlock && !unlock_q) begin
      unlock_q     <= 1'b1; // RULE14
      unlock_cnt_q <= 3'h0; // RULE24
    end else if (unlock_q && tick) begin
      if (unlock_cnt_q == (UNLOCK_TICKS - 3'h1)) begin
        unlock_q     <= 1'b0; // RULE16
        unlock_cnt_q <= 3'h0;
      end else begin
        unlock_cnt_q <= unlock_cnt_q + 3'h1; // RULE24
      end
    end
  end

  assign O_DIV_UNLOCKED = unlock_q;

  // Divide select as software sees it. Reset value follows the fuse; an
  // unlocked write of a legal code is taken regardless of the fuse.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      div_sel_q <= div8_fuse_s_q ? DIVSEL_RST_DIV8 : DIVSEL_RST_DIV1; // RULE18
    end else if (wr_divsel && sel_legal) begin
      div_sel_q <= I_WR_DATA[DIVSEL_MSB:0]; // RULE19
    end
  end // A reserved code leaves the factor unchanged. RULE23

  // The active factor changes only at the end of a divided period, so the
  // old period always completes and the new one starts whole.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      div_applied_q <= div8_fuse_s_q ? DIVSEL_RST_DIV8 : DIVSEL_RST_DIV1;
    end else if (tick) begin
      div_applied_q <= div_sel_q; // RULE11 RULE12
    end
  end

  sccp_prescale #(
    .CNT_W (PRESCALE_CNT_W)
  ) u_prescale (
    .i_clk      (I_CLK_SYS),
    .i_rst      (I_SRST),
    .i_div_log2 (div_applied_q),
    .o_tick     (tick)
  ); // RULE10 RULE13

  assign O_DIV_LOG2   = div_applied_q; // RULE10
  assign O_SYS_CLK_EN = tick && ready; // RULE10

  // Read port: data stand in the cycle after the strobe. The counter
  // inside the prescaler has no address.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      rd_data_q <= RD_UNMAPPED;
    end else if (I_RD_STB && (I_ADDR == ADDR_OSC_TRIM)) begin
      rd_data_q <= {1'b0, trim_q};
    end else if (I_RD_STB && (I_ADDR == ADDR_DIV_CTRL)) begin
      rd_data_q <= {unlock_q, 3'h0, div_sel_q}; // RULE13
    end else begin
      rd_data_q <= RD_UNMAPPED;
    end
  end

  assign O_RD_DATA = rd_data_q;

endmodule : sccp_top

// File: dv/sccp_top_checker.sv
// Purpose: Concurrent checks on the ports of the clock control block.
// Assumes: Fuse levels change only while reset is held.
// Notes:   Counters stand in for long repetitions in the window checks.
`timescale 1ns/10ps
module sccp_top_checker
  import sccp_pkg::*;
#(
  parameter int unsigned WDT_SHORT = 512,
  parameter int unsigned WDT_LONG  = 8192
) (
  input wire logic                        I_CLK_SYS,
  input wire logic                        I_SRST,
  input wire logic [sccp_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [sccp_pkg::DATA_W-1:0] I_WR_DATA,
  input wire logic                        I_WR_STB,
  input wire logic                        I_RD_STB,
  input wire logic [sccp_pkg::DATA_W-1:0] O_RD_DATA,
  input wire logic [6:0]                  I_FACTORY_TRIM,
  input wire logic [3:0]                  I_CLOCK_SOURCE_FUSE,
  input wire logic                        I_INITIAL_DIV8_FUSE,
  input wire logic                        I_POWER_DOWN,
  input wire logic [6:0]                  O_TRIM_VALUE,
  input wire sccp_pkg::sccp_src_t         O_CLOCK_SOURCE,
  input wire logic                        O_OSC_INPUT_EN,
  input wire logic                        O_SYS_CLK_EN,
  input wire logic [3:0]                  O_DIV_LOG2,
  input wire logic                        O_CLK_READY,
  input wire logic                        O_DIV_UNLOCKED
);
  logic [11:0] ul_cnt_q;
  logic [9:0]  gap_q;
  logic        seen_q;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_SRST);
  function automatic sccp_src_t exp_src(input logic [3:0] f);
    case (f)
      CKSRC_EXT_A, CKSRC_EXT_B: exp_src = SRC_EXT;
      CKSRC_RC4_A, CKSRC_RC4_B: exp_src = SRC_RC4M;
      CKSRC_RC8_A, CKSRC_RC8_B: exp_src = SRC_RC8M;
      CKSRC_LP128K:             exp_src = SRC_LP128K;
      default:                  exp_src = SRC_UNSUPPORTED;
    endcase
  endfunction : exp_src
  // Counts cycles spent unlocked, so a restarted window shows as overlong.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || !O_DIV_UNLOCKED) ul_cnt_q <= 12'h000;
    else ul_cnt_q <= ul_cnt_q + 12'h001;
  end
  // Gap since the last enable; cleared when not ready, as gating hides ticks.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || !O_CLK_READY) begin
      gap_q  <= 10'h000;
      seen_q <= 1'b0;
    end else if (O_SYS_CLK_EN) begin
      gap_q  <= 10'h001;
      seen_q <= 1'b1;
    end else gap_q <= gap_q + 10'h001;
  end
  chk_trim_write: assert property (I_WR_STB && I_ADDR == ADDR_OSC_TRIM
    |=> O_TRIM_VALUE == $past(I_WR_DATA[6:0])) else $error("trim write lost");
  chk_trim_read: assert property (I_RD_STB && I_ADDR == ADDR_OSC_TRIM
    |=> O_RD_DATA == {1'b0, $past(O_TRIM_VALUE)}) else $error("trim read bad");
  chk_ctrl_read: assert property (I_RD_STB && I_ADDR == ADDR_DIV_CTRL
    |=> O_RD_DATA[7] == $past(O_DIV_UNLOCKED) && O_RD_DATA[6:4] == 3'h0)
    else $error("control read bad");
  chk_unlock_set: assert property (!O_DIV_UNLOCKED && I_WR_STB
    && I_ADDR == ADDR_DIV_CTRL && I_WR_DATA == UNLOCK_WORD |=> O_DIV_UNLOCKED)
    else $error("no unlock");
  chk_unlock_guard: assert property (!O_DIV_UNLOCKED && I_WR_STB
    && I_ADDR == ADDR_DIV_CTRL && I_WR_DATA != UNLOCK_WORD |=> !O_DIV_UNLOCKED)
    else $error("unlock by wrong word");
  chk_unlock_clear: assert property (O_DIV_UNLOCKED && I_WR_STB
    && I_ADDR == ADDR_DIV_CTRL && !I_WR_DATA[7] |=> !O_DIV_UNLOCKED)
    else $error("unlock kept after value write");
  chk_unlock_window: assert property (O_DIV_UNLOCKED
    |-> ul_cnt_q < (12'h004 << O_DIV_LOG2)) else $error("unlock too long");
  chk_tick_period: assert property (O_SYS_CLK_EN && seen_q
    |-> gap_q == (10'h001 << O_DIV_LOG2)) else $error("enable period bad");
  chk_div_range: assert property (O_DIV_LOG2 <= DIVSEL_MAX)
    else $error("divide code reserved");
  chk_rst_div: assert property ($fell(I_SRST) |-> O_DIV_LOG2 ==
    (I_INITIAL_DIV8_FUSE ? DIVSEL_RST_DIV8 : DIVSEL_RST_DIV1))
    else $error("reset divide bad");
  chk_rst_trim: assert property ($fell(I_SRST)
    |-> O_TRIM_VALUE == I_FACTORY_TRIM) else $error("reset trim bad");
  chk_src_decode: assert property (!$past(I_SRST)
    |-> O_CLOCK_SOURCE == exp_src(I_CLOCK_SOURCE_FUSE)
    && O_OSC_INPUT_EN == (I_CLOCK_SOURCE_FUSE[3:1] == 3'h0))
    else $error("source decode bad");
  chk_wake_hold: assert property ($fell(I_POWER_DOWN)
    |-> !O_CLK_READY [*4]) else $error("wake too early");
endmodule : sccp_top_checker

bind sccp_top sccp_top_checker #(.WDT_SHORT(WDT_SHORT), .WDT_LONG(WDT_LONG))
  u_chk (.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .I_ADDR(I_ADDR),
  .I_WR_DATA(I_WR_DATA), .I_WR_STB(I_WR_STB), .I_RD_STB(I_RD_STB),
  .O_RD_DATA(O_RD_DATA), .I_FACTORY_TRIM(I_FACTORY_TRIM),
  .I_CLOCK_SOURCE_FUSE(I_CLOCK_SOURCE_FUSE),
  .I_INITIAL_DIV8_FUSE(I_INITIAL_DIV8_FUSE), .I_POWER_DOWN(I_POWER_DOWN),
  .O_TRIM_VALUE(O_TRIM_VALUE), .O_CLOCK_SOURCE(O_CLOCK_SOURCE),
  .O_OSC_INPUT_EN(O_OSC_INPUT_EN), .O_SYS_CLK_EN(O_SYS_CLK_EN),
  .O_DIV_LOG2(O_DIV_LOG2), .O_CLK_READY(O_CLK_READY),
  .O_DIV_UNLOCKED(O_DIV_UNLOCKED));

// File: dv/sccp_wdt_model.sv
// Purpose: Free-running watchdog oscillator seen from outside the block.
// Assumes: Its phase bears no relation to the master clock.
// Notes:   Runs free, as the real oscillator does, even outside start-up.
`timescale 1ns/10ps
module sccp_wdt_model #(
  parameter realtime HALF = 18.5
) (
  output logic o_osc
);
  initial begin
    o_osc = 1'b0;
    #3.3;
    forever #(HALF) o_osc = ~o_osc;
  end
endmodule : sccp_wdt_model

// File: dv/sccp_top_tb_top.sv
// Purpose: Self-checking bench for the clock control block.
// Assumes: Small watchdog counts of 4 and 8 stand in for 512 and 8192.
// Notes:   Reads are checked from a queue of expected values.
`timescale 1ns/10ps
module sccp_top_tb_top;
  import sccp_pkg::*;
  localparam int WS = 4;
  localparam int WL = 8;
  logic       clk, srst, wr_stb, rd_stb, div8, pd, wdt, osc_en, clk_en;
  logic       ready, unl;
  logic       rd_pend = 1'b0;
  logic [3:0] addr, src, dlog, c, old;
  logic [1:0] startup_delay_fuse;
  logic [6:0] ftrim, trim_o, v;
  logic [7:0] wdata, rdata;
  logic [7:0] exp_q[$];
  sccp_src_t  csrc;
  integer     seed;
  int         bad_count, n_tests, n, e, t;
  sccp_top #(.WDT_SHORT(WS), .WDT_LONG(WL)) dut (.I_CLK_SYS(clk),
    .I_SRST(srst), .I_ADDR(addr), .I_WR_DATA(wdata), .I_WR_STB(wr_stb),
    .I_RD_STB(rd_stb), .O_RD_DATA(rdata), .I_FACTORY_TRIM(ftrim),
    .I_CLOCK_SOURCE_FUSE(src), .I_STARTUP_DELAY_FUSE(startup_delay_fuse),
    .I_INITIAL_DIV8_FUSE(div8), .I_WDT_OSC(wdt), .I_POWER_DOWN(pd),
    .O_TRIM_VALUE(trim_o), .O_CLOCK_SOURCE(csrc), .O_OSC_INPUT_EN(osc_en),
    .O_SYS_CLK_EN(clk_en), .O_DIV_LOG2(dlog), .O_CLK_READY(ready),
    .O_DIV_UNLOCKED(unl));
  sccp_wdt_model u_wdt (.o_osc(wdt));
  // A steady master clock; frequency is never changed outside reset.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic close_out();
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t port value %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t read data %h expected %h", $time, got, exp);
    end
  endtask : cmp_rd
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask : rd
  task automatic do_rst(input logic [3:0] s, input logic [1:0] u,
                        input logic d8, input logic [6:0] tr);
    @(posedge clk);
    srst  <= 1'b1;
    src   <= s;
    startup_delay_fuse   <= u;
    div8  <= d8;
    ftrim <= tr;
    repeat (5) @(posedge clk);
    srst  <= 1'b0;
  endtask : do_rst
  task automatic wait_ready(output int k);
    k = 0;
    while (ready !== 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask : wait_ready
  // Read data stands only in the cycle after the strobe, so look mid-cycle.
  always @(negedge clk) begin
    if (rd_pend) cmp_rd(rdata, exp_q.pop_front());
    rd_pend = rd_stb;
  end
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    close_out();
  end
  initial begin
    seed = 32'hfc5f_879b;
    {srst, wr_stb, rd_stb, div8, pd} = 5'h10;
    {addr, src, startup_delay_fuse, ftrim, wdata} = '0;
    bad_count = 0;
    n_tests = 0;
    for (int i = 0; i < 16; i++) begin
      do_rst(4'(i), 2'(i), i[2], 7'($random(seed)));
      wait_ready(n);
      e = (i % 4 == 0) ? 0 : ((i % 4 == 1) ? WS : WL);
      cmp_val(16'(n >= 13 + ((e > 0) ? (e - 1) * 7 : 0) && n <= 16 + e * 8),
              16'h0001);
      cmp_val({15'h0, osc_en}, (i < 2) ? 16'h0001 : 16'h0000);
      cmp_val({12'h0, dlog}, i[2] ? 16'h0003 : 16'h0000);
      rd(ADDR_OSC_TRIM, {1'b0, ftrim});
    end
    @(posedge clk);
    pd <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    cmp_val({15'h0, ready}, 16'h0000);
    @(posedge clk);
    pd <= 1'b0;
    wait_ready(n);
    cmp_val(16'(n >= 5 && n <= 8), 16'h0001);
    // Steps stay below 0x20, and no memory write runs beside them.
    v = ftrim;
    repeat (4) begin
      v = v + 7'($random(seed) & 32'h0000_001f);
      wr(ADDR_OSC_TRIM, {1'b1, v});
      rd(ADDR_OSC_TRIM, {1'b0, v});
    end
    wr(4'hf, 8'ha5);
    rd(4'hf, RD_UNMAPPED);
    wr(ADDR_DIV_CTRL, 8'h81);
    rd(ADDR_DIV_CTRL, 8'h03);
    wr(ADDR_DIV_CTRL, 8'h05);
    rd(ADDR_DIV_CTRL, 8'h03);
    wr(ADDR_DIV_CTRL, UNLOCK_WORD);
    rd(ADDR_DIV_CTRL, 8'h83);
    wr(ADDR_DIV_CTRL, UNLOCK_WORD);
    repeat (4 * 8) @(posedge clk);
    wr(ADDR_DIV_CTRL, 8'h01);
    rd(ADDR_DIV_CTRL, 8'h03);
    // Stepping by seven visits every code once, reserved ones included.
    for (int k = 0; k < 16; k++) begin
      c = 4'(k * 7);
      old = dlog;
      wr(ADDR_DIV_CTRL, UNLOCK_WORD);
      wr(ADDR_DIV_CTRL, {4'h0, c});
      t = 0;
      for (int j = 1; j <= (2 << old) + 4; j++) begin
        @(posedge clk);
        #1;
        if (t == 0 && dlog !== old) t = j;
      end
      cmp_val({12'h0, dlog}, {12'h0, (c <= DIVSEL_MAX) ? c : old});
      if (c <= DIVSEL_MAX && c != old)
        cmp_val(16'(t > 0 && t <= (1 << old) + 1), 16'h0001);
      if (c <= DIVSEL_MAX) rd(ADDR_DIV_CTRL, {4'h0, c});
    end
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule : sccp_top_tb_top
